// File: src/sfp_regs.svh
// Register offsets, field positions, reset values and sizes of the pin control block
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

`define SFP_NSUP 12
`define SFP_NMRG 8
`define SFP_NFLT 3
`define SFP_AW 8
`define SFP_HTRANS_ACT_BIT 1

`define SFP_OFF_SUP_POL 8'h00
`define SFP_OFF_SUP_DRIVE 8'h04
`define SFP_OFF_SUP_GSEL 8'h08
`define SFP_OFF_GOUT_VAL 8'h0C
`define SFP_OFF_MRG_EN 8'h10
`define SFP_OFF_MRG_GSEL 8'h14
`define SFP_OFF_MRG_DUTY_LO 8'h18
`define SFP_OFF_MRG_DUTY_HI 8'h1C
`define SFP_OFF_FLT_ASSERT_BASE 8'h20
`define SFP_OFF_FLT_SHUT_BASE 8'h2C
`define SFP_FLT_STRIDE 8'h04
`define SFP_OFF_STATUS 8'h38
`define SFP_OFF_IRQ_STAT 8'h3C
`define SFP_OFF_IRQ_MASK 8'h40

`define SFP_RST_SUP_POL 12'hFFF
`define SFP_RST_SUP_DRIVE 12'h000
`define SFP_RST_ZERO 32'h0000_0000

`define SFP_ST_LINE_LSB 0
`define SFP_ST_STATE_LSB 4
`define SFP_ST_SHUT_LSB 8
`define SFP_GOUT_MRG_LSB 12
`define SFP_GOUT_W 20

`define SFP_IRQ_W 4
`define SFP_IRQ_SHUT_BIT 3

`define SFP_DUTY_W 8
`define SFP_PWM_FULL 8'hFF
`define SFP_PWM_LAST 8'hFE

`endif

// File: src/sfp_pkg.sv
// Types shared by the pin control block
package sfp_pkg;

  typedef enum logic [1:0] {ST_HIZ, ST_PULL, ST_MON} sfp_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } sfp_aph_type;

endpackage

// File: src/sfp_pwm.sv
// One margin pulse channel: free counter and duty compare
`timescale 1ns/10ps
`include "sfp_regs.svh"

module sfp_pwm
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] duty,
  output logic pulse
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic pulse_nxt;

  assign cnt_nxt = (cnt_r == `SFP_PWM_LAST) ? 8'h00 : cnt_r + 8'h01;
  // Full scale never drops low, not even for one count
  assign pulse_nxt = (duty == `SFP_PWM_FULL) | (cnt_r < duty); // R5

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 8'h00;
      pulse <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      pulse <= pulse_nxt;
    end
  end

endmodule

// File: src/sfp_top.sv
// Supply enable, margin pulse and shared fault line pin control with AHB-Lite registers
`timescale 1ns/10ps
`include "sfp_regs.svh"

// Notes on behaviour
// R1: Each supply enable has its own active-high or active-low polarity bit.
// R2: Each supply enable drives either open drain or push-pull.
// R3: Any supply enable may instead be a general output.
// R4: A margin pulse pin with margining off floats.
// R5: Full-scale duty holds the margin pin high without any low phase.
// R6: Any margin pulse pin may instead be a general output.
// R7: The three fault lines are driven and sensed independently.
// R8: Per line, a channel mask picks which channel faults pull that line.
// R9: Per line, a channel mask picks which channels shut down when it asserts.
// R10: In reset and before recall, fault lines are released whatever faults exist.
// R11: After recall completes every fault line is pulled low until monitoring.
// R12: Once monitoring runs a line is released only with no enabled faults.
// R13: During reset all supply, margin and fault pins float.
// R14: Fault lines are active-low open drain, shared and readable by all.
// R15: Fault line inputs pass two flip-flops before triggering shutdown.
module sfp_top
  import sfp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [11:0] chan_fault,
  input wire logic [11:0] supply_on_req,
  input wire logic recall_done,
  input wire logic monitor_start,
  output logic [11:0] supply_enable_outputs,
  output logic [11:0] supply_enable_oe_n,
  output logic [7:0] margin_pulse_outputs,
  output logic [7:0] margin_pulse_oe_n,
  input wire logic [2:0] shared_fault_lines_in,
  output logic [2:0] shared_fault_lines_out,
  output logic [2:0] shared_fault_lines_oe_n,
  output logic [11:0] chan_shutdown,
  output logic irq
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  sfp_aph_type aph_r;
  sfp_aph_type aph_nxt;
  logic rd_wait_r;
  logic rd_wait_nxt;
  logic [31:0] rd_data;
  wire aph_take = hsel & hready & htrans[`SFP_HTRANS_ACT_BIT];
  wire wr_en = aph_r.valid & aph_r.write;
  wire [7:0] rsel = aph_r.addr;

  // One wait state on reads so the answer comes from a flip-flop
  assign rd_wait_nxt = aph_r.valid & ~aph_r.write & ~rd_wait_r;
  assign hreadyout = ~rd_wait_nxt;
  assign hresp = 1'b0;
  assign aph_nxt = !hready ? aph_r :
                   aph_take ? sfp_aph_type'{valid: 1'b1, write: hwrite, addr: haddr[7:0]} : '0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_r <= '0;
      rd_wait_r <= 1'b0;
      hrdata <= `SFP_RST_ZERO;
    end
    else
    begin
      aph_r <= aph_nxt;
      rd_wait_r <= rd_wait_nxt;
      if (rd_wait_nxt)
        hrdata <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [11:0] sup_pol_r;
  logic [11:0] sup_drive_r;
  logic [11:0] sup_gsel_r;
  logic [19:0] gout_val_r;
  logic [7:0] mrg_en_r;
  logic [7:0] mrg_gsel_r;
  logic [31:0] duty_lo_r;
  logic [31:0] duty_hi_r;
  logic [3:0] irq_mask_r;
  logic [11:0] flt_assert_r [3];
  logic [11:0] flt_shut_r [3];

  wire wr_pol = wr_en & (rsel == `SFP_OFF_SUP_POL);
  wire wr_drive = wr_en & (rsel == `SFP_OFF_SUP_DRIVE);
  wire wr_gsel = wr_en & (rsel == `SFP_OFF_SUP_GSEL);
  wire wr_gout = wr_en & (rsel == `SFP_OFF_GOUT_VAL);
  wire wr_men = wr_en & (rsel == `SFP_OFF_MRG_EN);
  wire wr_mgsel = wr_en & (rsel == `SFP_OFF_MRG_GSEL);
  wire wr_dlo = wr_en & (rsel == `SFP_OFF_MRG_DUTY_LO);
  wire wr_dhi = wr_en & (rsel == `SFP_OFF_MRG_DUTY_HI);
  wire wr_istat = wr_en & (rsel == `SFP_OFF_IRQ_STAT);
  wire wr_imask = wr_en & (rsel == `SFP_OFF_IRQ_MASK);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sup_pol_r <= `SFP_RST_SUP_POL;
      sup_drive_r <= `SFP_RST_SUP_DRIVE;
      sup_gsel_r <= 12'h000;
      gout_val_r <= 20'h00000;
      mrg_en_r <= 8'h00;
      mrg_gsel_r <= 8'h00;
      duty_lo_r <= `SFP_RST_ZERO;
      duty_hi_r <= `SFP_RST_ZERO;
      irq_mask_r <= 4'h0;
    end
    else
    begin
      if (wr_pol) sup_pol_r <= hwdata[11:0]; // R1
      if (wr_drive) sup_drive_r <= hwdata[11:0]; // R2
      if (wr_gsel) sup_gsel_r <= hwdata[11:0]; // R3
      if (wr_gout) gout_val_r <= hwdata[19:0];
      if (wr_men) mrg_en_r <= hwdata[7:0]; // R4
      if (wr_mgsel) mrg_gsel_r <= hwdata[7:0]; // R6
      if (wr_dlo) duty_lo_r <= hwdata;
      if (wr_dhi) duty_hi_r <= hwdata;
      if (wr_imask) irq_mask_r <= hwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Fault line sync, state and per-line masks
  // ----------------------------------------------------------------
  sfp_state_type st_r;
  sfp_state_type st_nxt;
  logic [2:0] flt_s1_r;
  logic [2:0] flt_s2_r;
  logic [2:0] line_act_d_r;
  logic [2:0] flt_oe_n_nxt;
  logic [11:0] shut_vec [3];
  logic [31:0] flt_rd [3];
  wire [2:0] line_act = ~flt_s2_r;
  wire hiz = (st_r == ST_HIZ);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flt_s1_r <= 3'h7;
      flt_s2_r <= 3'h7;
      line_act_d_r <= 3'h0;
    end
    else
    begin
      flt_s1_r <= shared_fault_lines_in; // R15
      flt_s2_r <= flt_s1_r; // R15
      line_act_d_r <= line_act;
    end
  end

  // Recall and monitor start come from on-chip logic on this clock
  assign st_nxt = (hiz && recall_done) ? ST_PULL :
                  ((st_r == ST_PULL) && monitor_start) ? ST_MON : st_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= ST_HIZ; // R10
    else
      st_r <= st_nxt; // R11
  end

  genvar l;
  generate
    for (l = 0; l < `SFP_NFLT; l++)
    begin : g_line
      wire [7:0] off_a = `SFP_OFF_FLT_ASSERT_BASE + 8'(l) * `SFP_FLT_STRIDE;
      wire [7:0] off_s = `SFP_OFF_FLT_SHUT_BASE + 8'(l) * `SFP_FLT_STRIDE;
      wire pulled = |(flt_assert_r[l] & chan_fault); // R8
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          flt_assert_r[l] <= 12'h000;
          flt_shut_r[l] <= 12'h000;
        end
        else
        begin
          if (wr_en && rsel == off_a) flt_assert_r[l] <= hwdata[11:0]; // R8
          if (wr_en && rsel == off_s) flt_shut_r[l] <= hwdata[11:0]; // R9
        end
      end
      // Each line looks only at its own mask and its own sense bit
      assign flt_oe_n_nxt[l] = hiz | ((st_r == ST_MON) & ~pulled); // R7 R11 R12
      assign shut_vec[l] = flt_shut_r[l] & {12{line_act[l]}}; // R9
      assign flt_rd[l] = (rsel == off_a) ? 32'(flt_assert_r[l]) :
                         (rsel == off_s) ? 32'(flt_shut_r[l]) : `SFP_RST_ZERO;
    end
  endgenerate

  wire [11:0] shut_nxt = shut_vec[0] | shut_vec[1] | shut_vec[2]; // R9

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [7:0] pwm_raw;
  wire [63:0] duty_all = {duty_hi_r, duty_lo_r};
  wire [11:0] sup_act = supply_on_req & ~chan_shutdown;
  wire [11:0] sup_lvl = (sup_gsel_r & gout_val_r[11:0]) | (~sup_gsel_r & ~(sup_act ^ sup_pol_r)); // R1 R3
  wire [7:0] mrg_gval = gout_val_r[`SFP_GOUT_W-1:`SFP_GOUT_MRG_LSB];
  wire [7:0] mrg_lvl = (mrg_gsel_r & mrg_gval) | (~mrg_gsel_r & pwm_raw); // R6
  // Open drain never drives high; the pin's pullup supplies the level
  wire [11:0] sup_out_nxt = sup_drive_r & sup_lvl; // R2
  wire [11:0] sup_oe_n_nxt = {12{hiz}} | (~sup_drive_r & sup_lvl); // R2 R13
  wire [7:0] mrg_oe_n_nxt = {8{hiz}} | ~(mrg_en_r | mrg_gsel_r); // R4 R13

  genvar c;
  generate
    for (c = 0; c < `SFP_NMRG; c++)
    begin : g_mrg
      sfp_pwm u_pwm
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .duty(duty_all[c*`SFP_DUTY_W +: `SFP_DUTY_W]),
        .pulse(pwm_raw[c])
      );
    end
  endgenerate

  // Fault lines only ever pull low
  assign shared_fault_lines_out = 3'h0; // R14

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      supply_enable_outputs <= 12'h000;
      supply_enable_oe_n <= 12'hFFF; // R13
      margin_pulse_outputs <= 8'h00;
      margin_pulse_oe_n <= 8'hFF; // R13
      shared_fault_lines_oe_n <= 3'h7; // R10
      chan_shutdown <= 12'h000;
    end
    else
    begin
      supply_enable_outputs <= sup_out_nxt;
      supply_enable_oe_n <= sup_oe_n_nxt;
      margin_pulse_outputs <= mrg_lvl; // R5
      margin_pulse_oe_n <= mrg_oe_n_nxt;
      shared_fault_lines_oe_n <= flt_oe_n_nxt; // R14
      chan_shutdown <= shut_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and read mux
  // ----------------------------------------------------------------
  logic [3:0] irq_stat_r;
  wire [3:0] irq_ev = {|(shut_nxt & ~chan_shutdown), line_act & ~line_act_d_r};
  wire [3:0] irq_clr = wr_istat ? hwdata[3:0] : 4'h0;
  // A new event in the clearing cycle survives
  wire [3:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_r <= 4'h0;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  wire [31:0] status_word = (32'(line_act) << `SFP_ST_LINE_LSB) |
                            (32'(st_r) << `SFP_ST_STATE_LSB) |
                            (32'(chan_shutdown) << `SFP_ST_SHUT_LSB);

  assign rd_data = (rsel == `SFP_OFF_SUP_POL) ? 32'(sup_pol_r) :
                   (rsel == `SFP_OFF_SUP_DRIVE) ? 32'(sup_drive_r) :
                   (rsel == `SFP_OFF_SUP_GSEL) ? 32'(sup_gsel_r) :
                   (rsel == `SFP_OFF_GOUT_VAL) ? 32'(gout_val_r) :
                   (rsel == `SFP_OFF_MRG_EN) ? 32'(mrg_en_r) :
                   (rsel == `SFP_OFF_MRG_GSEL) ? 32'(mrg_gsel_r) :
                   (rsel == `SFP_OFF_MRG_DUTY_LO) ? duty_lo_r :
                   (rsel == `SFP_OFF_MRG_DUTY_HI) ? duty_hi_r :
                   (rsel == `SFP_OFF_STATUS) ? status_word :
                   (rsel == `SFP_OFF_IRQ_STAT) ? 32'(irq_stat_r) :
                   (rsel == `SFP_OFF_IRQ_MASK) ? 32'(irq_mask_r) :
                   (flt_rd[0] | flt_rd[1] | flt_rd[2]);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_POLARITY: assert property ( // R1
    (!hiz && !sup_gsel_r[1] && sup_drive_r[1] && supply_on_req[1] && !chan_shutdown[1])
    |=> (supply_enable_outputs[1] == $past(sup_pol_r[1])))
    else $error("supply enable level ignores polarity");

  AST_OPEN_DRAIN: assert property ( // R2
    (!hiz && !sup_drive_r[1])
    |=> (!supply_enable_outputs[1] && (supply_enable_oe_n[1] == $past(sup_lvl[1]))))
    else $error("open drain supply enable drove high");

  AST_SUP_GOUT: assert property ( // R3
    (!hiz && sup_gsel_r[3] && sup_drive_r[3])
    |=> (supply_enable_outputs[3] == $past(gout_val_r[3])) && !supply_enable_oe_n[3])
    else $error("supply enable general output wrong");

  AST_MRG_FLOAT: assert property ( // R4
    (!mrg_en_r[0] && !mrg_gsel_r[0]) |=> margin_pulse_oe_n[0])
    else $error("margin pin driven while margining off");

  AST_FULL_DUTY: assert property ( // R5
    (!mrg_gsel_r[0] && duty_lo_r[7:0] == `SFP_PWM_FULL)[*2] |=> margin_pulse_outputs[0])
    else $error("full duty margin pin went low");

  AST_MRG_GOUT: assert property ( // R6
    (!hiz && mrg_gsel_r[1])
    |=> (margin_pulse_outputs[1] == $past(gout_val_r[13])) && !margin_pulse_oe_n[1])
    else $error("margin general output wrong");

  AST_LINE_INDEP: assert property ( // R7
    (st_r == ST_MON && (flt_assert_r[1] & chan_fault) == 12'h000) |=> shared_fault_lines_oe_n[1])
    else $error("fault line held by another line's fault");

  AST_ASSERT_MASK: assert property ( // R8
    (st_r == ST_MON && (flt_assert_r[0] & chan_fault) != 12'h000) |=> !shared_fault_lines_oe_n[0])
    else $error("enabled channel fault did not pull line");

  AST_SHUTDOWN: assert property ( // R9
    (flt_shut_r[2][5] && !shared_fault_lines_in[2])[*3] |=> chan_shutdown[5])
    else $error("masked fault line did not shut channel down");

  AST_PRE_RECALL: assert property ( // R10
    hiz |=> (shared_fault_lines_oe_n == 3'h7))
    else $error("fault line driven before recall");

  AST_RECALL_PULL: assert property ( // R11
    (hiz && recall_done) |=> (st_r == ST_PULL) ##1 (shared_fault_lines_oe_n == 3'h0))
    else $error("fault lines not pulled after recall");

  AST_MON_RELEASE: assert property ( // R12
    (st_r == ST_PULL && monitor_start) ##1 ((flt_assert_r[2] & chan_fault) == 12'h000)
    |=> shared_fault_lines_oe_n[2])
    else $error("fault line not released at monitor start");

  AST_HIZ_PINS: assert property ( // R13
    hiz |=> (&supply_enable_oe_n && &margin_pulse_oe_n))
    else $error("pins driven before recall");

  AST_SYNC_DELAY: assert property ( // R15
    $fell(shared_fault_lines_in[0]) |=> ##1 line_act[0])
    else $error("fault input not seen after two stages");

endmodule

// File: test/sfp_peer.sv
// Peer device and pull-up model on the three shared fault lines
`timescale 1ns/10ps

module sfp_peer
(
  input wire logic [2:0] dut_out,
  input wire logic [2:0] dut_oe_n,
  input wire logic [2:0] pull_n,
  output logic [2:0] line
);
  // ----------------------------------------
  // Wired AND
  // ----------------------------------------
  // Pull-up on every line, so a released line reads high, not its last level
  assign line = (dut_oe_n | dut_out) & pull_n;
endmodule

// File: test/sfp_top_test.sv
// Self-checking bench for the supply, margin and fault line pin block
`timescale 1ns/10ps
`include "sfp_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module sfp_top_test;
  import sfp_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [11:0] chan_fault = 12'hFFF;
  logic [11:0] supply_on_req = 12'h000;
  logic recall_done = 1'b0;
  logic monitor_start = 1'b0;
  logic [11:0] sup_out;
  logic [11:0] sup_oe_n;
  logic [7:0] mrg_out;
  logic [7:0] mrg_oe_n;
  logic [2:0] flt_line;
  logic [2:0] flt_out;
  logic [2:0] flt_oe_n;
  logic [2:0] peer_pull_n = 3'h7;
  logic [11:0] chan_shutdown;
  logic irq;
  int bad_count = 0;
  int cmp_count = 0;

  always #12.5 hclk = ~hclk;

  sfp_top sfp_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .chan_fault(chan_fault), .supply_on_req(supply_on_req),
    .recall_done(recall_done), .monitor_start(monitor_start), .supply_enable_outputs(sup_out),
    .supply_enable_oe_n(sup_oe_n), .margin_pulse_outputs(mrg_out), .margin_pulse_oe_n(mrg_oe_n),
    .shared_fault_lines_in(flt_line), .shared_fault_lines_out(flt_out),
    .shared_fault_lines_oe_n(flt_oe_n), .chan_shutdown(chan_shutdown), .irq(irq));

  sfp_peer sfp_peer_i (.dut_out(flt_out), .dut_oe_n(flt_oe_n), .pull_n(peer_pull_n), .line(flt_line));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Looks at hready before the edge, so the edge's own updates never race the test
  task automatic wait_ready(output logic [31:0] rd);
    logic ok;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge hclk);
      ok = (hreadyout === 1'b1);
      rd = hrdata;
      @(posedge hclk);
      if (ok)
        return;
    end
    bad_count++;
    report_and_stop();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(x, e)
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    repeat (4) @(posedge hclk);
    #1;
    `CHK({sup_oe_n, mrg_oe_n, flt_oe_n}, 23'h7FFFFF)
    `CHK(flt_oe_n, 3'h7)
    @(posedge hclk);
    hresetn <= 1'b1;
    step(3);
    `CHK(flt_oe_n, 3'h7)
  endtask

  task automatic t_regs;
    rd_chk(`SFP_OFF_SUP_POL, 32'h0000_0FFF);
    rd_chk(`SFP_OFF_SUP_DRIVE, 32'h0000_0000);
    wr(8'h80, 32'hFFFF_FFFF);
    rd_chk(8'h80, 32'h0000_0000);
    `CHK(hresp, 1'b0)
  endtask

  task automatic t_sequence;
    wr(8'h20, 32'h0000_0001);
    wr(8'h24, 32'h0000_0002);
    @(posedge hclk);
    chan_fault <= 12'h001;
    recall_done <= 1'b1;
    @(posedge hclk);
    recall_done <= 1'b0;
    step(1);
    `CHK(flt_oe_n, 3'h0)
    step(5);
    `CHK(flt_oe_n, 3'h0)
    @(posedge hclk);
    monitor_start <= 1'b1;
    @(posedge hclk);
    monitor_start <= 1'b0;
    step(2);
    `CHK(flt_oe_n, 3'h6)
    @(posedge hclk);
    chan_fault <= 12'h002;
    step(2);
    `CHK(flt_oe_n, 3'h5)
    @(posedge hclk);
    chan_fault <= 12'h003;
    step(2);
    `CHK(flt_oe_n, 3'h4)
  endtask

  task automatic t_irq;
    rd_chk(`SFP_OFF_IRQ_STAT, 32'h0000_0007);
    step(1);
    `CHK(irq, 1'b0)
    wr(`SFP_OFF_IRQ_MASK, 32'h0000_000F);
    step(1);
    `CHK(irq, 1'b1)
    wr(`SFP_OFF_IRQ_STAT, 32'h0000_0007);
    step(1);
    `CHK(irq, 1'b0)
  endtask

  // A peer pulls line 2 while this device holds it released
  task automatic t_peer;
    wr(8'h34, 32'h0000_0020);
    @(posedge hclk);
    peer_pull_n <= 3'h3;
    step(2);
    `CHK(chan_shutdown, 12'h000)
    step(1);
    `CHK(chan_shutdown, 12'h020)
    step(2);
    `CHK(irq, 1'b1)
    rd_chk(`SFP_OFF_STATUS, 32'h0000_2027);
    `CHK(flt_out, 3'h0)
    rd_chk(`SFP_OFF_IRQ_STAT, 32'h0000_000C);
    wr(`SFP_OFF_IRQ_STAT, 32'h0000_000C);
    @(posedge hclk);
    peer_pull_n <= 3'h7;
    step(4);
    `CHK(chan_shutdown, 12'h000)
    `CHK(irq, 1'b0)
  endtask

  task automatic t_supply;
    wr(`SFP_OFF_SUP_POL, 32'h0000_000A);
    wr(`SFP_OFF_SUP_DRIVE, 32'h0000_000A);
    wr(`SFP_OFF_SUP_GSEL, 32'h0000_0008);
    wr(`SFP_OFF_GOUT_VAL, 32'h0000_2008);
    @(posedge hclk);
    supply_on_req <= 12'h006;
    step(2);
    `CHK(sup_out[3:1], 3'h5)
    `CHK(sup_oe_n[3:1], 3'h0)
    @(posedge hclk);
    supply_on_req <= 12'h000;
    step(2);
    `CHK(sup_out[3:1], 3'h4)
    `CHK(sup_oe_n[3:1], 3'h2)
  endtask

  task automatic t_margin;
    logic hi;
    `CHK(mrg_oe_n, 8'hFF)
    wr(`SFP_OFF_MRG_EN, 32'h0000_0001);
    wr(`SFP_OFF_MRG_GSEL, 32'h0000_0002);
    wr(`SFP_OFF_MRG_DUTY_LO, 32'h0000_00FF);
    step(3);
    `CHK(mrg_oe_n, 8'hFC)
    `CHK(mrg_out[1], 1'b1)
    hi = 1'b1;
    for (int n = 0; n < 300; n++)
    begin
      step(1);
      hi = hi & mrg_out[0];
    end
    `CHK(hi, 1'b1)
  endtask

  // Reset in mid-run with faults pending and pins driven
  task automatic t_rereset;
    @(posedge hclk);
    hresetn <= 1'b0;
    step(1);
    `CHK(flt_oe_n, 3'h7)
    `CHK({sup_oe_n, mrg_oe_n}, 20'hFFFFF)
    @(posedge hclk);
    hresetn <= 1'b1;
    step(2);
    `CHK(flt_oe_n, 3'h7)
    `CHK(chan_shutdown, 12'h000)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    t_reset();
    t_regs();
    t_sequence();
    t_irq();
    t_peer();
    t_supply();
    t_margin();
    t_rereset();
    report_and_stop();
  end
endmodule
